//--- fpcd_pkg.sv
// Package of the flash protect command sequencer: codes, bus addresses, register map and timing.
// Assumes a 20 MHz system clock and a x16 flash whose command addresses are word addresses.
package fpcd_pkg;

    // ------------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------------
    localparam int CLK_NS       = 50;
    localparam int T_WP_NS      = 35;   // Least write strobe low time.
    localparam int T_WPH_NS     = 30;   // Least write strobe high time.
    localparam int T_ACC_NS     = 110;  // Read access time.
    localparam int T_RP_NS      = 500;  // Hardware reset pulse.
    localparam int WP_CYC       = (T_WP_NS + CLK_NS - 1) / CLK_NS;
    localparam int WPH_CYC      = (T_WPH_NS + CLK_NS - 1) / CLK_NS;
    localparam int ACC_CYC      = (T_ACC_NS + CLK_NS - 1) / CLK_NS + 1;
    localparam int RP_CYC       = (T_RP_NS + CLK_NS - 1) / CLK_NS;

    // ------------------------------------------------------------------
    // Command codes and unlock addresses
    // ------------------------------------------------------------------
    localparam logic [15:0] A_555 = 16'h0555;
    localparam logic [15:0] A_2AA = 16'h02aa;
    localparam logic [15:0] A_55  = 16'h0055;
    localparam logic [15:0] A_00  = 16'h0000;
    localparam logic [7:0] C_AA = 8'haa, C_55 = 8'h55, C_90 = 8'h90, C_00 = 8'h00, C_01 = 8'h01;
    localparam logic [7:0] C_F0 = 8'hf0, C_98 = 8'h98, C_A0 = 8'ha0, C_25 = 8'h25, C_29 = 8'h29;
    localparam logic [7:0] C_20 = 8'h20, C_80 = 8'h80, C_30 = 8'h30, C_B0 = 8'hb0, C_88 = 8'h88;
    localparam logic [7:0] C_03 = 8'h03;
    localparam logic [7:0] C_SET_LOCKREG = 8'h40;
    localparam logic [7:0] C_SET_PW      = 8'h60;
    localparam logic [7:0] C_SET_PPB     = 8'hc0;
    localparam logic [7:0] C_SET_FREEZE  = 8'h50;
    localparam logic [7:0] C_SET_DYB     = 8'he0;
    localparam logic [15:0] A_AS_PROT    = 16'h0002;
    localparam logic [15:0] A_AS_SECURE  = 16'h0003;
    localparam int BIT_SERIAL  = 7;
    localparam int BIT_LOCK    = 0;

    // ------------------------------------------------------------------
    // Software register map (word index)
    // ------------------------------------------------------------------
    localparam logic [7:0] R_CTRL   = 8'h00;
    localparam logic [7:0] R_ADDR   = 8'h01;
    localparam logic [7:0] R_DATA   = 8'h02;
    localparam logic [7:0] R_COUNT  = 8'h03;
    localparam logic [7:0] R_STATUS = 8'h04;
    localparam logic [7:0] R_RDATA  = 8'h05;
    localparam logic [7:0] R_BUF    = 8'h10;
    localparam int CTRL_OP_LSB  = 0;
    localparam int CTRL_ERS_DONE = 8;

    typedef enum logic [5:0] {
        OP_RESET, OP_READ, OP_AS_PROT, OP_AS_SECURE, OP_CFI, OP_PROGRAM, OP_WTB, OP_WTB_ABORT,
        OP_UB_ENTRY, OP_UB_PROGRAM, OP_UB_ERASE, OP_UB_RESET, OP_SECTOR_ERASE, OP_SUSPEND,
        OP_RESUME, OP_SEC_ENTRY, OP_SEC_PROGRAM, OP_SEC_READ, OP_SEC_EXIT, OP_SET_ENTRY,
        OP_SET_EXIT, OP_SET_PROGRAM, OP_SET_READ, OP_PW_UNLOCK, OP_PPB_ERASE, OP_HW_RESET
    } fpcd_op_e;

    typedef enum logic [3:0] {
        M_READ, M_AUTOSEL, M_BYPASS, M_SECURED, M_LOCKREG, M_PASSWORD, M_PPB, M_FREEZE, M_DYB
    } fpcd_mode_e;

    typedef struct packed {
        logic [15:0] addr;
        logic [15:0] data;
        logic        rd;
        logic        last;
    } fpcd_step_s;

endpackage

//--- fpcd_host.sv
// Host controller that issues command sequences to a parallel NOR flash over its strobe pins.
// Assumes software on a plain strobe port and a flash answering reads within the access time.
`timescale 1ns/1ns

// What this block does
// - Address set before fall, data held past rise.
// - Only legal sequences issued; reset restores reading.
// - Buffer load addresses stay in one page.
// - Word count is locations minus one.
// - Secured commands after entry; exit required.
// - Set entry selects by third data code.
// - Set exit is 90 then 00.
// - Lock erase 80/30; lock program A0/00.
// - Password portions by two low address bits.
// - Unlock sends all seven cycles with portions.
module fpcd_host
    import fpcd_pkg::*;
#(
    parameter int FA_W       = 24,
    parameter int PAGE_BITS  = 4,
    parameter int BUF_DEPTH  = 16
) (
    // Clock and reset
    input  wire logic              clk,
    input  wire logic              rst,
    // Software register port
    input  wire logic [7:0]        sw_addr,
    input  wire logic [31:0]       sw_wdata,
    input  wire logic              sw_wr,
    input  wire logic              sw_rd,
    output logic      [31:0]       sw_rdata,
    // Flash pins
    output logic      [FA_W-1:0]   fl_addr,
    output logic      [15:0]       fl_dq_out,
    output logic                   fl_dq_oe,
    input  wire logic [15:0]       fl_dq_in,
    output logic                   fl_ce_n,
    output logic                   fl_we_n,
    output logic                   fl_oe_n,
    output logic                   fl_reset_n
);

    typedef enum logic [2:0] {S_IDLE, S_SETUP, S_LOW, S_HIGH, S_RST} fpcd_state_e;

    // ------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------
    fpcd_state_e state_q, state_d;
    fpcd_mode_e  mode_q, mode_d;
    fpcd_op_e    op_q, op_d;
    logic [15:0] addr_q, addr_d, data_q, data_d, rdata_q, rdata_d;
    logic [7:0]  count_q, count_d, cnt_q, cnt_d;
    logic [4:0]  step_q, step_d;
    logic        err_q, err_d, erasing_q, erasing_d, susp_q, susp_d, prot_q, prot_d, serial_q, serial_d;
    logic [15:0] buf_q [BUF_DEPTH];
    logic [31:0] sw_rdata_d;
    fpcd_step_s  cur;
    logic [15:0] buf_word;
    int          buf_idx;

    // Address within the write buffer page of the starting address.
    function automatic logic [15:0] page_addr(logic [15:0] base, int idx);
        logic [15:0] off;
        off = base + 16'(idx);
        return {base[15:PAGE_BITS], off[PAGE_BITS-1:0]};
    endfunction

    function automatic fpcd_step_s mk(logic [15:0] a, logic [7:0] d, logic rd, logic last);
        return '{addr: a, data: {8'h00, d}, rd: rd, last: last};
    endfunction

    // Step k of the sequence for an order; unlock pair first where the order starts with one.
    function automatic fpcd_step_s step_of(fpcd_op_e op, int k, logic [15:0] a, logic [15:0] d,
                                            logic [7:0] wc, logic [15:0] bw, fpcd_mode_e m);
        fpcd_step_s s;
        logic [7:0] c3;
        s = mk(A_00, C_00, 1'b0, 1'b1);
        c3 = C_00;
        case (op)
            OP_AS_PROT, OP_AS_SECURE, OP_SEC_EXIT: c3 = C_90;
            OP_PROGRAM, OP_SEC_PROGRAM:            c3 = C_A0;
            OP_WTB_ABORT:                          c3 = C_F0;
            OP_UB_ENTRY:                           c3 = C_20;
            OP_SECTOR_ERASE:                       c3 = C_80;
            OP_SEC_ENTRY:                          c3 = C_88;
            OP_SET_ENTRY:                          c3 = d[7:0];
            default:                               c3 = C_00;
        endcase
        case (op)
            OP_RESET:     s = mk(A_00, C_F0, 1'b0, 1'b1);
            OP_READ, OP_SEC_READ: s = mk(a, C_00, 1'b1, 1'b1);
            OP_CFI:       s = mk(A_55, C_98, 1'b0, 1'b1);
            OP_SUSPEND:   s = mk(A_00, C_B0, 1'b0, 1'b1);
            OP_RESUME:    s = mk(A_00, C_30, 1'b0, 1'b1);
            OP_UB_PROGRAM, OP_SET_PROGRAM:
                s = (k == 0) ? mk(A_00, C_A0, 1'b0, 1'b0)
                             : '{addr: a, data: (m == M_PPB || m == M_FREEZE) ? 16'h0000 :
                                 (m == M_DYB) ? {8'h00, d[7:0]} : d, rd: 1'b0, last: 1'b1};
            OP_UB_ERASE:  s = (k == 0) ? mk(A_00, C_80, 1'b0, 1'b0) : mk(a, C_30, 1'b0, 1'b1);
            OP_UB_RESET, OP_SET_EXIT:
                s = (k == 0) ? mk(A_00, C_90, 1'b0, 1'b0) : mk(A_00, C_00, 1'b0, 1'b1);
            OP_PPB_ERASE: s = (k == 0) ? mk(A_00, C_80, 1'b0, 1'b0) : mk(A_00, C_30, 1'b0, 1'b1);
            OP_SET_READ:  s = mk(a, C_00, 1'b1, 1'b1);
            OP_PW_UNLOCK: begin
                case (k)
                    0:       s = mk(A_00, C_25, 1'b0, 1'b0);
                    1:       s = mk(A_00, C_03, 1'b0, 1'b0);
                    6:       s = mk(A_00, C_29, 1'b0, 1'b1);
                    default: s = '{addr: 16'(k - 2), data: bw, rd: 1'b0, last: 1'b0};
                endcase
            end
            OP_WTB: begin
                if (k == 0) begin
                    s = mk(A_555, C_AA, 1'b0, 1'b0);
                end else if (k == 1) begin
                    s = mk(A_2AA, C_55, 1'b0, 1'b0);
                end else if (k == 2) begin
                    s = mk(a, C_25, 1'b0, 1'b0);
                end else if (k == 3) begin
                    s = mk(a, wc, 1'b0, 1'b0);
                end else if (k <= 4 + int'(wc)) begin
                    s = '{addr: page_addr(a, k - 4), data: bw, rd: 1'b0, last: 1'b0};
                end else begin
                    s = mk(a, C_29, 1'b0, 1'b1);
                end
            end
            default: begin
                case (k)
                    0:       s = mk(A_555, C_AA, 1'b0, 1'b0);
                    1:       s = mk((op == OP_WTB_ABORT) ? a : A_2AA, C_55, 1'b0, 1'b0);
                    2:       s = mk(A_555, c3, 1'b0, op inside {OP_WTB_ABORT, OP_UB_ENTRY, OP_SEC_ENTRY, OP_SET_ENTRY});
                    3: begin
                        case (op)
                            OP_AS_PROT:   s = mk(a | A_AS_PROT, C_00, 1'b1, 1'b1);
                            OP_AS_SECURE: s = mk(A_AS_SECURE, C_00, 1'b1, 1'b1);
                            OP_SEC_EXIT:  s = mk(A_00, C_00, 1'b0, 1'b1);
                            OP_SECTOR_ERASE: s = mk(A_555, C_AA, 1'b0, 1'b0);
                            default:      s = '{addr: a, data: d, rd: 1'b0, last: 1'b1};
                        endcase
                    end
                    4:       s = mk(A_2AA, C_55, 1'b0, 1'b0);
                    default: s = mk(a, C_30, 1'b0, 1'b1);
                endcase
            end
        endcase
        return s;
    endfunction

    // Whether an order may be issued in the current mode.
    function automatic logic legal(fpcd_op_e op, fpcd_mode_e m, logic ers, logic sus, logic [7:0] wc,
                                   logic [7:0] sel);
        logic ok;
        logic prot;
        prot = m inside {M_LOCKREG, M_PASSWORD, M_PPB, M_FREEZE, M_DYB};
        case (op)
            OP_HW_RESET:                ok = 1'b1;
            OP_READ:                    ok = (m == M_READ) || (m == M_BYPASS);
            OP_RESET:                   ok = !prot && m != M_BYPASS && m != M_SECURED;
            OP_CFI:                     ok = (m == M_READ) || (m == M_AUTOSEL);
            OP_AS_PROT, OP_AS_SECURE:   ok = (m == M_READ) && (!ers || sus);
            OP_PROGRAM:                 ok = (m == M_READ) && (!ers || sus);
            OP_WTB:                     ok = (m == M_READ) && !ers && int'(wc) < BUF_DEPTH;
            OP_WTB_ABORT:               ok = (m == M_READ);
            OP_UB_ENTRY, OP_SEC_ENTRY:  ok = (m == M_READ) && !ers;
            OP_UB_PROGRAM, OP_UB_ERASE, OP_UB_RESET: ok = (m == M_BYPASS);
            OP_SECTOR_ERASE:            ok = (m == M_READ) && !ers;
            OP_SUSPEND:                 ok = ers && !sus;
            OP_RESUME:                  ok = sus && (m == M_READ);
            OP_SEC_PROGRAM, OP_SEC_READ, OP_SEC_EXIT: ok = (m == M_SECURED);
            OP_SET_ENTRY:               ok = (m == M_READ) && !ers && sel inside {C_SET_LOCKREG, C_SET_PW,
                                             C_SET_PPB, C_SET_FREEZE, C_SET_DYB};
            OP_SET_EXIT, OP_SET_PROGRAM: ok = prot;
            OP_SET_READ:                ok = prot && m != M_PASSWORD;
            OP_PW_UNLOCK:               ok = (m == M_PASSWORD);
            OP_PPB_ERASE:               ok = (m == M_PPB);
            default:                    ok = 1'b0;
        endcase
        return ok;
    endfunction

    function automatic fpcd_mode_e set_mode(logic [7:0] sel);
        case (sel)
            C_SET_LOCKREG: return M_LOCKREG;
            C_SET_PW:      return M_PASSWORD;
            C_SET_PPB:     return M_PPB;
            C_SET_FREEZE:  return M_FREEZE;
            default:       return M_DYB;
        endcase
    endfunction

    // ------------------------------------------------------------------
    // Sequencer
    // ------------------------------------------------------------------
    always_comb begin
        buf_idx = 0;
        if (op_q == OP_WTB && step_q >= 5'd4) begin
            buf_idx = int'(step_q) - 4;
        end else if (op_q == OP_PW_UNLOCK && step_q >= 5'd2) begin
            buf_idx = int'(step_q) - 2;
        end
        if (buf_idx >= BUF_DEPTH) begin
            buf_idx = 0;
        end
        buf_word = buf_q[buf_idx];
        cur = step_of(op_q, int'(step_q), addr_q, data_q, count_q, buf_word, mode_q);
    end

    always_comb begin
        state_d   = state_q;
        mode_d    = mode_q;
        op_d      = op_q;
        addr_d    = addr_q;
        data_d    = data_q;
        count_d   = count_q;
        cnt_d     = cnt_q;
        step_d    = step_q;
        err_d     = err_q;
        erasing_d = erasing_q;
        susp_d    = susp_q;
        rdata_d   = rdata_q;
        prot_d    = prot_q;
        serial_d  = serial_q;
        if (sw_wr && sw_addr == R_ADDR) addr_d = sw_wdata[15:0];
        if (sw_wr && sw_addr == R_DATA) data_d = sw_wdata[15:0];
        if (sw_wr && sw_addr == R_COUNT) count_d = sw_wdata[7:0];
        if (sw_wr && sw_addr == R_CTRL && sw_wdata[CTRL_ERS_DONE]) begin
            erasing_d = 1'b0;
            susp_d    = 1'b0;
        end
        case (state_q)
            S_IDLE: begin
                if (sw_wr && sw_addr == R_CTRL && !sw_wdata[CTRL_ERS_DONE]) begin
                    op_d   = fpcd_op_e'(sw_wdata[CTRL_OP_LSB +: 6]);
                    step_d = '0;
                    if (!legal(op_d, mode_q, erasing_q, susp_q, count_q, data_q[7:0])) begin
                        err_d = 1'b1;
                    end else if (op_d == OP_HW_RESET) begin
                        err_d   = 1'b0;
                        state_d = S_RST;
                        cnt_d   = 8'(RP_CYC);
                    end else begin
                        err_d   = 1'b0;
                        state_d = S_SETUP;
                    end
                end
            end
            S_SETUP: begin
                state_d = S_LOW;
                cnt_d   = cur.rd ? 8'(ACC_CYC) : 8'(WP_CYC);
            end
            S_LOW: begin
                cnt_d = cnt_q - 8'd1;
                if (cnt_q == 8'd1) begin
                    state_d = S_HIGH;
                    cnt_d   = 8'(WPH_CYC);
                    if (cur.rd) begin
                        rdata_d = fl_dq_in;
                        case (mode_q)
                            M_PPB, M_DYB: prot_d = !fl_dq_in[BIT_LOCK];
                            M_FREEZE:     prot_d = fl_dq_in[BIT_LOCK];
                            default:      prot_d = (fl_dq_in[7:0] == C_01);
                        endcase
                        if (op_q == OP_AS_SECURE) serial_d = fl_dq_in[BIT_SERIAL];
                    end
                end
            end
            S_HIGH: begin
                cnt_d = cnt_q - 8'd1;
                if (cnt_q == 8'd1) begin
                    step_d  = step_q + 5'd1;
                    state_d = cur.last ? S_IDLE : S_SETUP;
                    if (cur.last) begin
                        case (op_q)
                            OP_RESET, OP_SET_EXIT, OP_UB_RESET, OP_SEC_EXIT: mode_d = M_READ;
                            OP_AS_PROT, OP_AS_SECURE: mode_d = M_AUTOSEL;
                            OP_UB_ENTRY:     mode_d = M_BYPASS;
                            OP_SEC_ENTRY:    mode_d = M_SECURED;
                            OP_SET_ENTRY:    mode_d = set_mode(data_q[7:0]);
                            OP_SECTOR_ERASE, OP_UB_ERASE: erasing_d = 1'b1;
                            OP_SUSPEND:      susp_d = 1'b1;
                            OP_RESUME:       susp_d = 1'b0;
                            default:         mode_d = mode_q;
                        endcase
                    end
                end
            end
            S_RST: begin
                cnt_d = cnt_q - 8'd1;
                if (cnt_q == 8'd1) begin
                    state_d   = S_IDLE;
                    mode_d    = M_READ;
                    erasing_d = 1'b0;
                    susp_d    = 1'b0;
                end
            end
            default: state_d = S_IDLE;
        endcase
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            state_q <= S_IDLE;
            mode_q <= M_READ;
            op_q <= OP_READ;
            addr_q <= '0;
            data_q <= '0;
            count_q <= '0;
            cnt_q <= '0;
            step_q <= '0;
            err_q <= 1'b0;
            erasing_q <= 1'b0;
            susp_q <= 1'b0;
            rdata_q <= '0;
            prot_q <= 1'b0;
            serial_q <= 1'b0;
        end else begin
            state_q <= state_d;
            mode_q <= mode_d;
            op_q <= op_d;
            addr_q <= addr_d;
            data_q <= data_d;
            count_q <= count_d;
            cnt_q <= cnt_d;
            step_q <= step_d;
            err_q <= err_d;
            erasing_q <= erasing_d;
            susp_q <= susp_d;
            rdata_q <= rdata_d;
            prot_q <= prot_d;
            serial_q <= serial_d;
        end
    end

    // Buffer words carry the write-buffer data and the four password portions.
    always_ff @(posedge clk) begin
        if (sw_wr && sw_addr >= R_BUF && int'(sw_addr - R_BUF) < BUF_DEPTH) begin
            buf_q[int'(sw_addr - R_BUF)] <= sw_wdata[15:0];
        end
    end

    // ------------------------------------------------------------------
    // Register read and pins
    // ------------------------------------------------------------------
    always_comb begin
        sw_rdata_d = '0;
        if (sw_rd) begin
            case (sw_addr)
                R_ADDR:   sw_rdata_d = {16'h0000, addr_q};
                R_DATA:   sw_rdata_d = {16'h0000, data_q};
                R_COUNT:  sw_rdata_d = {24'h000000, count_q};
                R_STATUS: sw_rdata_d = {21'h000000, mode_q, serial_q, prot_q, susp_q, erasing_q,
                                        err_q, 1'b0, (state_q != S_IDLE)};
                R_RDATA:  sw_rdata_d = {16'h0000, rdata_q};
                default:  sw_rdata_d = '0;
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            sw_rdata <= '0;
        end else begin
            sw_rdata <= sw_rdata_d;
        end
    end

    // Address and data stand through setup, low and high phases, so the flash sees the address
    // before the falling strobe and the data well past the rising one.
    always_comb begin
        fl_addr    = FA_W'(cur.addr);
        fl_dq_out  = cur.data;
        fl_dq_oe   = (state_q inside {S_SETUP, S_LOW, S_HIGH}) && !cur.rd;
        fl_ce_n    = !(state_q == S_LOW);
        fl_we_n    = !(state_q == S_LOW && !cur.rd);
        fl_oe_n    = !(state_q == S_LOW && cur.rd);
        fl_reset_n = !(rst || state_q == S_RST);
    end

endmodule

//--- fpcd_host_chk.sv
// Pin checker of the flash host.
// Assumes it is bound to fpcd_host and sees the same port names.
`timescale 1ns/1ns
module fpcd_host_chk #(
    parameter int FA_W = 24
) (
    // Clock, reset and flash pins
    input wire logic            clk,
    input wire logic            rst,
    input wire logic [FA_W-1:0] fl_addr,
    input wire logic [15:0]     fl_dq_out,
    input wire logic            fl_dq_oe,
    input wire logic            fl_ce_n,
    input wire logic            fl_we_n,
    input wire logic            fl_oe_n,
    input wire logic            fl_reset_n
);
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    sequence s_held; $stable(fl_addr) && $stable(fl_dq_out) && fl_dq_oe; endsequence
    sequence s_rd_low; !fl_oe_n [*4] ##1 fl_oe_n; endsequence
    property p_wr_sel; !fl_we_n |-> !fl_ce_n && fl_oe_n; endproperty
    a_wr_sel: assert property (p_wr_sel) else $error("write strobe without select");
    property p_wr_one; $fell(fl_we_n) |=> fl_we_n; endproperty
    a_wr_one: assert property (p_wr_one) else $error("write strobe too long");
    property p_wr_setup; $fell(fl_we_n) |-> s_held; endproperty
    a_wr_setup: assert property (p_wr_setup) else $error("bus moved at strobe fall");
    property p_wr_hold; $rose(fl_we_n) |-> s_held; endproperty
    a_wr_hold: assert property (p_wr_hold) else $error("bus moved at strobe rise");
    property p_rd_len; $fell(fl_oe_n) |-> s_rd_low; endproperty
    a_rd_len: assert property (p_rd_len) else $error("read strobe length wrong");
    property p_rd_sel; !fl_oe_n |-> !fl_ce_n && fl_we_n && !fl_dq_oe; endproperty
    a_rd_sel: assert property (p_rd_sel) else $error("read with bad strobes");
    property p_hi_zero; fl_addr[FA_W-1:16] == '0; endproperty
    a_hi_zero: assert property (p_hi_zero) else $error("unused address bits set");
    property p_rst_len; $fell(fl_reset_n) |-> !fl_reset_n [*8]; endproperty
    a_rst_len: assert property (p_rst_len) else $error("flash reset pulse short");
endmodule

bind fpcd_host fpcd_host_chk #(.FA_W(FA_W)) i_fpcd_host_chk (.*);

//--- fpcd_flash_model.sv
// Behavioural flash device answering the protection command sets.
// Assumes word addresses with the sector number in address bits 15:12.
`timescale 1ns/1ns
module fpcd_flash_model #(
    parameter logic SER = 1'b1
) (
    // Flash pins
    input  wire logic [23:0] fl_addr,
    input  wire logic [15:0] fl_dq_out,
    input  wire logic        fl_dq_oe,
    input  wire logic        fl_ce_n,
    input  wire logic        fl_we_n,
    input  wire logic        fl_oe_n,
    input  wire logic        fl_reset_n,
    output logic      [15:0] fl_dq_in
);
    logic [15:0] la, a1, a2, volatile_sector_lock, v;
    logic [15:0] persistent_sector_lock = 16'h0000;
    logic [7:0]  m, c, d1, d2;
    logic        frz;
    always @(negedge (fl_we_n | fl_ce_n)) la = fl_addr[15:0];
    always @(posedge (fl_we_n | fl_ce_n) or negedge fl_reset_n) begin
        if (!fl_reset_n) begin
            {m, d1, d2, volatile_sector_lock, frz} = '0;
        end else begin
            c = fl_dq_out[7:0];
            if (c == 8'hf0) m = 8'h00;
            else if (m != 8'h00 && d1 == 8'h90 && c == 8'h00) m = 8'h00;
            else if (d2 == 8'haa && a2 == 16'h0555 && d1 == 8'h55 && a1 == 16'h02aa) m = c;
            else if (d1 == 8'ha0 && m == 8'he0) volatile_sector_lock[la[15:12]] = (c == 8'h00);
            else if (d1 == 8'ha0 && m == 8'hc0) persistent_sector_lock[la[15:12]] = 1'b1;
            else if (d1 == 8'h80 && c == 8'h30 && m == 8'hc0) persistent_sector_lock = '0;
            else if (d1 == 8'ha0 && m == 8'h50) frz = 1'b1;
            {a2, d2, a1, d1} = {a1, d1, la, c};
        end
    end
    always_comb begin
        case (m)
            8'h90: v = (fl_addr[7:0] == 8'h03) ? {8'h00, SER, 7'h00}
                : {15'h0, persistent_sector_lock[fl_addr[15:12]] | volatile_sector_lock[fl_addr[15:12]]};
            8'hc0: v = {15'h0, !persistent_sector_lock[fl_addr[15:12]]};
            8'he0: v = {15'h0, !volatile_sector_lock[fl_addr[15:12]]};
            8'h50: v = {15'h0, frz};
            default: v = fl_addr[15:0] ^ 16'h5a5a;
        endcase
        // An undriven bus shows the inverse so stale data never passes.
        fl_dq_in = (!fl_oe_n && !fl_ce_n && !fl_dq_oe) ? v : ~v;
    end
endmodule

//--- tb_fpcd_host.sv
// Bench of the flash host: orders over the software port, a flash model on the pins.
// Assumes the register map and status layout of the host package.
`timescale 1ns/1ns
module tb_fpcd_host;
    import fpcd_pkg::*;
    logic        clk = 1'b0, rst = 1'b1, sw_wr = 1'b0, sw_rd = 1'b0, rd_d = 1'b0;
    logic [7:0]  sw_addr = 8'h00;
    logic [31:0] sw_wdata = 32'h0, sw_rdata;
    logic [23:0] fl_addr;
    logic [15:0] fl_dq_out, fl_dq_in, ra;
    logic        fl_dq_oe, fl_ce_n, fl_we_n, fl_oe_n, fl_reset_n;
    logic [63:0] exp_q[$], e;
    int          mismatches = 0, cmp_count = 0, cyc = 0, seed = 32'h2c6b33bc;
    logic [7:0]  codes[5] = '{8'h40, 8'h60, 8'hc0, 8'h50, 8'he0};
    fpcd_mode_e  modes[5] = '{M_LOCKREG, M_PASSWORD, M_PPB, M_FREEZE, M_DYB};
    always #25 clk = ~clk;
    fpcd_host i_fpcd_host (.*);
    fpcd_flash_model i_fpcd_flash_model (.*);
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        {sw_addr, sw_wdata, sw_wr} <= {a, d, 1'b1};
        @(posedge clk);
        sw_wr <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] ex, input logic [31:0] mk);
        @(posedge clk);
        exp_q.push_back({mk, ex});
        {sw_addr, sw_rd} <= {a, 1'b1};
        @(posedge clk);
        sw_rd <= 1'b0;
    endtask
    // Status polls carry an empty mask, so the monitor skips them.
    task automatic opc(input fpcd_op_e o, input logic [31:0] ex = 0, input logic [31:0] mk = 0);
        wr(R_CTRL, 32'(o));
        repeat (100) begin
            rd(R_STATUS, 32'h0, 32'h0);
            @(negedge clk);
            if (sw_rdata[0] === 1'b0) break;
        end
        if (mk != 0) rd(R_STATUS, ex, mk);
    endtask
    task automatic final_report();
        $display("comparisons %0d, mismatches %0d", cmp_count, mismatches);
        if (mismatches == 0 && cmp_count > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask
    always @(posedge clk) begin
        rd_d <= sw_rd;
        cyc <= cyc + 1;
        if (rd_d && exp_q.size() > 0) begin
            e = exp_q.pop_front();
            cmp_count += (e[63:32] != 0);
            if (e[63:32] != 0 && (sw_rdata & e[63:32]) !== (e[31:0] & e[63:32])) begin
                mismatches++;
                $display("[ERR] %0t ns: read %h, expected %h", $time, sw_rdata, e[31:0]);
            end
        end
        if (cyc == 20000) begin
            mismatches++;
            final_report();
        end
    end
    initial begin
        repeat (6) @(posedge clk);
        rst <= 1'b0;
        ra = 16'($random(seed));
        wr(R_ADDR, {16'h0, ra});
        opc(OP_READ);
        rd(R_RDATA, {16'h0, ra ^ 16'h5a5a}, 32'hffff);
        $display("array read done");
        for (int i = 0; i < 5; i++) begin
            wr(8'h3f, 32'hffffffff);
            wr(R_DATA, {24'h0, codes[i]});
            opc(OP_SET_ENTRY, 32'(modes[i]) << 7, 32'h780);
            opc(OP_SET_EXIT, 32'(M_READ) << 7, 32'h780);
        end
        $display("set entry and exit done");
        wr(R_ADDR, {16'h0, ra[15:12], 12'h000});
        for (int k = 0; k < 2; k++) begin
            wr(R_DATA, 32'he0);
            opc(OP_SET_ENTRY);
            wr(R_DATA, 32'(k));
            opc(OP_SET_PROGRAM);
            opc(OP_SET_READ, k == 0 ? 32'h20 : 32'h0, 32'h20);
            opc(OP_SET_EXIT);
            opc(OP_AS_PROT, k == 0 ? 32'h20 : 32'h0, 32'h20);
            opc(OP_RESET);
        end
        opc(OP_AS_SECURE, 32'h40, 32'h40);
        opc(OP_RESET);
        $display("volatile lock and autoselect done");
        wr(R_DATA, 32'hc0);
        opc(OP_SET_ENTRY);
        opc(OP_SET_PROGRAM);
        opc(OP_SET_READ, 32'h20, 32'h20);
        opc(OP_PPB_ERASE);
        opc(OP_SET_READ, 32'h0, 32'h20);
        opc(OP_SET_EXIT);
        wr(R_DATA, 32'h50);
        opc(OP_SET_ENTRY);
        opc(OP_SET_PROGRAM);
        opc(OP_SET_READ, 32'h20, 32'h20);
        opc(OP_HW_RESET, 32'(M_READ) << 7, 32'h780);
        wr(R_DATA, 32'he0);
        opc(OP_SET_ENTRY);
        opc(OP_CFI, 32'h4, 32'h4);
        $display("persistent lock, freeze and refusal done");
        final_report();
    end
endmodule
